// File: rtl/scc_pkg.sv
// constants, types and widths for the system clock source control
// assumes a single 50 MHz clock and oscillators sampled as pin inputs
package scc_pkg;
    localparam int          SRC_N       = 5;
    localparam int          SRC_W       = 3;
    localparam int          TRIM_W      = 8;
    localparam int          FREQ_W      = 6;
    localparam logic [5:0]  FREQ_DFLT   = 6'h18;
    localparam logic [5:0]  FREQ_MIN    = 6'h03;
    localparam logic [5:0]  FREQ_MAX    = 6'h30;
    localparam int          DIV_N       = 12;
    localparam int          DIV_INT_N   = 10;
    localparam int          DIV_W       = 16;
    localparam int          FRAC_W      = 5;
    localparam int          CAL_LEN_W   = 16;
    localparam int          CAL_CNT_W   = 24;
    localparam logic [15:0] DIV_ZERO    = 16'h0000;
    localparam logic [15:0] DIV_ONE     = 16'h0001;
    localparam logic [23:0] CAL_ZERO    = 24'h000000;
    localparam logic [23:0] CAL_ONE     = 24'h000001;
    localparam logic [15:0] LEN_ONE     = 16'h0001;

    typedef enum logic [2:0] {
        SRC_MAIN_RC  = 3'h0,
        SRC_LOW_RC   = 3'h1,
        SRC_FAST_XO  = 3'h2,
        SRC_WATCH_XO = 3'h3,
        SRC_EXT_PIN  = 3'h4
    } scc_src_e;

    typedef enum logic [1:0] {
        SW_RUN   = 2'b00,
        SW_DRAIN = 2'b01,
        SW_ACQ   = 2'b11
    } scc_sw_e;
endpackage

// File: rtl/scc_top.sv
// clock source selection, glitch-free switching, trim and peripheral enables
// assumes oscillators arrive as asynchronous pins; every rate is an enable pulse
// Overview of operation
// - every subsystem gets its enable; a source change never yields a runt pulse
// - all source pins and switching paths are synchronised against metastability
// - sources: main rc, low-speed rc, fast crystal, watch crystal, external pin
// - main oscillator starts at 24 MHz, retunable 3 to 48 MHz in 1 MHz steps
// - factory trim is loaded from the trim latch store without software action
// - software-supplied trim adjustments from flash are applied on top of factory trim
// - low-speed oscillator keeps clocking sleep peripherals while fast clocks stop
// - low-speed counter periods can be measured against the main oscillator
// - fast crystal clocks the radio when active and is selectable as system clock
// - watch crystal is the radio sleep clock timing its wake intervals
// - root clock feeds ten 16-bit integer and two 16.5-bit fractional dividers
// - watchdog counter runs from low-speed rc or watch crystal
module scc_top
(
    // clock and reset
    input  wire logic                          clock_i,
    input  wire logic                          nrst_i,
    // oscillator pins
    input  wire logic                          main_rc_oscillator_i,
    input  wire logic                          low_speed_rc_oscillator_i,
    input  wire logic                          fast_crystal_oscillator_i,
    input  wire logic                          watch_crystal_oscillator_i,
    input  wire logic                          ext_clk_pin_i,
    // source selection
    input  wire logic [scc_pkg::SRC_W-1:0]     src_sel_i,
    input  wire logic                          src_sel_we_i,
    input  wire logic                          deep_sleep_i,
    input  wire logic                          wdt_src_watch_i,
    // main oscillator tuning
    input  wire logic [scc_pkg::TRIM_W-1:0]    trim_latch_store_i,
    input  wire logic [scc_pkg::TRIM_W-1:0]    flash_trim_i,
    input  wire logic                          flash_trim_we_i,
    input  wire logic [scc_pkg::FREQ_W-1:0]    freq_mhz_i,
    input  wire logic                          freq_we_i,
    // peripheral dividers
    input  wire logic [scc_pkg::DIV_N*scc_pkg::DIV_W-1:0] div_int_i,
    input  wire logic [2*scc_pkg::FRAC_W-1:0]  div_frac_i,
    // low-speed calibration
    input  wire logic                          cal_start_i,
    input  wire logic [scc_pkg::CAL_LEN_W-1:0] cal_len_i,
    // clock enables
    output logic                               high_freq_root_clock_en_o,
    output logic                               lp_periph_clk_en_o,
    output logic                               radio_active_clk_en_o,
    output logic                               radio_sleep_clk_en_o,
    output logic                               wdt_clk_en_o,
    output logic [scc_pkg::DIV_N-1:0]          periph_clk_en_o,
    // status
    output logic [scc_pkg::SRC_W-1:0]          active_src_o,
    output logic                               switch_busy_o,
    output logic [scc_pkg::TRIM_W-1:0]         main_rc_trim_o,
    output logic [scc_pkg::FREQ_W-1:0]         main_rc_freq_o,
    output logic [scc_pkg::CAL_CNT_W-1:0]      cal_count_o,
    output logic                               cal_done_o
);
    import scc_pkg::*;
    logic [SRC_N-1:0]     sync1_reg;
    logic [SRC_N-1:0]     sync2_reg;
    logic [SRC_N-1:0]     sync3_reg;
    logic [SRC_N-1:0]     lvl_reg;
    logic [SRC_N-1:0]     lvl_next;
    logic [SRC_N-1:0]     edge_reg;
    logic [SRC_N-1:0]     pins;
    scc_sw_e              sw_state_reg;
    scc_src_e             cur_src_reg;
    scc_src_e             pend_src_reg;
    logic                 root_en_reg;
    logic                 lp_en_reg;
    logic                 radio_act_reg;
    logic                 radio_slp_reg;
    logic                 wdt_en_reg;
    logic [TRIM_W-1:0]    factory_trim_reg;
    logic [TRIM_W-1:0]    flash_trim_reg;
    logic [TRIM_W-1:0]    trim_sum_reg;
    logic                 trim_loaded_reg;
    logic [FREQ_W-1:0]    freq_reg;
    logic [DIV_W-1:0]     div_cnt_reg [DIV_N];
    logic [FRAC_W-1:0]    frac_acc_reg [2];
    logic [DIV_N-1:0]     div_pulse_reg;
    logic                 cal_run_reg;
    logic                 cal_done_reg;
    logic [CAL_LEN_W-1:0] cal_left_reg;
    logic [CAL_CNT_W-1:0] cal_cnt_reg;
    logic                 sel_valid;
    assign pins = {ext_clk_pin_i, watch_crystal_oscillator_i, fast_crystal_oscillator_i,
                   low_speed_rc_oscillator_i, main_rc_oscillator_i};

    // pin synchroniser, level changes once stages two and three agree
    assign lvl_next = (~(sync2_reg ^ sync3_reg) & sync3_reg)
                      | ((sync2_reg ^ sync3_reg) & lvl_reg);
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
            lvl_reg   <= '0;
            edge_reg  <= '0;
        end
        else
        begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            lvl_reg   <= lvl_next;
            edge_reg  <= lvl_next & ~lvl_reg;
        end
    end

    // glitch-free source switch: finish old period, wait a fresh new edge
    assign sel_valid = (src_sel_i <= SRC_EXT_PIN) && (src_sel_i != cur_src_reg);
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sw_state_reg <= SW_RUN;
            cur_src_reg  <= SRC_MAIN_RC;
            pend_src_reg <= SRC_MAIN_RC;
        end
        else
        begin
            case (sw_state_reg)
                SW_RUN:
                begin
                    if (src_sel_we_i && sel_valid)
                    begin
                        pend_src_reg <= scc_src_e'(src_sel_i);
                        sw_state_reg <= SW_DRAIN;
                    end
                end
                SW_DRAIN:
                begin
                    if (edge_reg[cur_src_reg])
                    begin
                        sw_state_reg <= SW_ACQ;
                    end
                end
                SW_ACQ:
                begin
                    if (edge_reg[pend_src_reg])
                    begin
                        cur_src_reg  <= pend_src_reg;
                        sw_state_reg <= SW_RUN;
                    end
                end
                default:
                begin
                    sw_state_reg <= SW_RUN;
                end
            endcase
        end
    end
    // clock enables towards the subsystems
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            root_en_reg   <= 1'b0;
            lp_en_reg     <= 1'b0;
            radio_act_reg <= 1'b0;
            radio_slp_reg <= 1'b0;
            wdt_en_reg    <= 1'b0;
        end
        else
        begin
            root_en_reg   <= (sw_state_reg == SW_RUN) && edge_reg[cur_src_reg]
                             && !deep_sleep_i;
            lp_en_reg     <= edge_reg[SRC_LOW_RC];
            radio_act_reg <= edge_reg[SRC_FAST_XO] && !deep_sleep_i;
            radio_slp_reg <= edge_reg[SRC_WATCH_XO];
            wdt_en_reg    <= wdt_src_watch_i ? edge_reg[SRC_WATCH_XO]
                                             : edge_reg[SRC_LOW_RC];
        end
    end

    // main oscillator trim and frequency code
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            factory_trim_reg <= '0;
            trim_loaded_reg  <= 1'b0;
            flash_trim_reg   <= '0;
            trim_sum_reg     <= '0;
        end
        else
        begin
            trim_sum_reg <= factory_trim_reg + flash_trim_reg;
            if (!trim_loaded_reg)
            begin
                factory_trim_reg <= trim_latch_store_i;
                trim_loaded_reg  <= 1'b1;
            end
            if (flash_trim_we_i)
            begin
                flash_trim_reg <= flash_trim_i;
            end
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            freq_reg <= FREQ_DFLT;
        end
        else if (freq_we_i && freq_mhz_i >= FREQ_MIN && freq_mhz_i <= FREQ_MAX)
        begin
            freq_reg <= freq_mhz_i;
        end
    end
    // peripheral dividers on the root enable, divide by value plus one
    for (genvar i = 0; i < DIV_N; i++)
    begin : g_div
        logic             extra;
        logic [DIV_W-1:0] limit;
        if (i >= DIV_INT_N)
        begin : g_frac
            logic [FRAC_W:0] sum;
            assign sum   = {1'b0, frac_acc_reg[i-DIV_INT_N]}
                           + {1'b0, div_frac_i[(i-DIV_INT_N)*FRAC_W +: FRAC_W]};
            assign extra = sum[FRAC_W];
            always_ff @(posedge clock_i or negedge nrst_i)
            begin
                if (!nrst_i)
                begin
                    frac_acc_reg[i-DIV_INT_N] <= '0;
                end
                else if (root_en_reg && div_cnt_reg[i] >= limit)
                begin
                    frac_acc_reg[i-DIV_INT_N] <= sum[FRAC_W-1:0];
                end
            end
        end
        else
        begin : g_int
            assign extra = 1'b0;
        end
        assign limit = div_int_i[i*DIV_W +: DIV_W] + (extra ? DIV_ONE : DIV_ZERO);
        always_ff @(posedge clock_i or negedge nrst_i)
        begin
            if (!nrst_i)
            begin
                div_cnt_reg[i]   <= '0;
                div_pulse_reg[i] <= 1'b0;
            end
            else
            begin
                div_pulse_reg[i] <= root_en_reg && div_cnt_reg[i] >= limit;
                if (root_en_reg)
                begin
                    div_cnt_reg[i] <= (div_cnt_reg[i] >= limit) ? DIV_ZERO
                                                               : div_cnt_reg[i] + DIV_ONE;
                end
            end
        end
    end
    // low-speed period measured in main oscillator edges
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cal_run_reg  <= 1'b0;
            cal_done_reg <= 1'b0;
            cal_left_reg <= '0;
            cal_cnt_reg  <= '0;
        end
        else if (cal_start_i && !cal_run_reg)
        begin
            cal_run_reg  <= 1'b1;
            cal_done_reg <= 1'b0;
            cal_left_reg <= cal_len_i;
            cal_cnt_reg  <= CAL_ZERO;
        end
        else if (cal_run_reg)
        begin
            if (edge_reg[SRC_MAIN_RC])
            begin
                cal_cnt_reg <= cal_cnt_reg + CAL_ONE;
            end
            if (edge_reg[SRC_LOW_RC])
            begin
                cal_left_reg <= cal_left_reg - LEN_ONE;
                if (cal_left_reg <= LEN_ONE)
                begin
                    cal_run_reg  <= 1'b0;
                    cal_done_reg <= 1'b1;
                end
            end
        end
    end
    assign high_freq_root_clock_en_o = root_en_reg;
    assign lp_periph_clk_en_o        = lp_en_reg;
    assign radio_active_clk_en_o     = radio_act_reg;
    assign radio_sleep_clk_en_o      = radio_slp_reg;
    assign wdt_clk_en_o              = wdt_en_reg;
    assign periph_clk_en_o           = div_pulse_reg;
    assign active_src_o              = cur_src_reg;
    assign switch_busy_o             = (sw_state_reg != SW_RUN);
    assign main_rc_trim_o            = trim_sum_reg;
    assign main_rc_freq_o            = freq_reg;
    assign cal_count_o               = cal_cnt_reg;
    assign cal_done_o                = cal_done_reg;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    sequence drain_done_s;
        sw_state_reg == SW_DRAIN && edge_reg[cur_src_reg];
    endsequence
    sequence acq_state_s;
        sw_state_reg == SW_ACQ;
    endsequence
    src_change_a: assert property ($changed(cur_src_reg) |-> $past(sw_state_reg) == SW_ACQ
                                   && $past(edge_reg[pend_src_reg]))
        else $error("source changed outside acquire");
    no_runt_a: assert property (root_en_reg |-> $past(sw_state_reg) == SW_RUN)
        else $error("root enable while switching");
    drain_step_a: assert property (drain_done_s |=> acq_state_s)
        else $error("drain did not move to acquire");
    sync_edge_a: assert property (edge_reg[SRC_MAIN_RC] |-> $past(sync3_reg[SRC_MAIN_RC], 1)
                                  && $past(sync2_reg[SRC_MAIN_RC], 2))
        else $error("edge without agreeing stages");
    freq_range_a: assert property (freq_reg >= FREQ_MIN && freq_reg <= FREQ_MAX)
        else $error("frequency code out of range");
    lp_clock_a: assert property (edge_reg[SRC_LOW_RC] |=> lp_en_reg)
        else $error("low-speed enable missing");
    sleep_stop_a: assert property (deep_sleep_i |=> !root_en_reg && !radio_act_reg)
        else $error("fast clocks run in deep sleep");
    radio_sleep_a: assert property (edge_reg[SRC_WATCH_XO] |=> radio_slp_reg)
        else $error("radio sleep enable missing");
    wdt_src_a: assert property (wdt_en_reg |-> $past(wdt_src_watch_i ? edge_reg[SRC_WATCH_XO]
                                                     : edge_reg[SRC_LOW_RC]))
        else $error("watchdog enable from wrong source");
endmodule

// File: verif/tb_system_clock_source_control.sv
// self-checking bench for the clock source control top level
// assumes oscillator pins are modelled as free-running square waves from the bench
module tb_system_clock_source_control;
    timeunit 1ns;
    timeprecision 1ps;
    import scc_pkg::*;

    logic                        clock_i = 1'b0;
    logic                        nrst_i = 1'b0;
    logic                        src_sel_we_i = 1'b0, deep_sleep_i = 1'b0, wdt_src_watch_i = 1'b0;
    logic                        flash_trim_we_i = 1'b0, freq_we_i = 1'b0, cal_start_i = 1'b0;
    logic [SRC_W-1:0]            src_sel_i = 3'h0;
    logic [TRIM_W-1:0]           trim_latch_store_i = 8'ha5, flash_trim_i = 8'h00;
    logic [FREQ_W-1:0]           freq_mhz_i = 6'h00;
    logic [DIV_N*DIV_W-1:0]      div_int_i = '0;
    logic [2*FRAC_W-1:0]         div_frac_i = '0;
    logic [CAL_LEN_W-1:0]        cal_len_i = 16'h0003;
    logic                        root_en, lp_en, ra_en, rs_en, wdt_en, busy, cal_done;
    logic [DIV_N-1:0]            per_en;
    logic [SRC_W-1:0]            act_src;
    logic [TRIM_W-1:0]           trim_o;
    logic [FREQ_W-1:0]           freq_o;
    logic [CAL_CNT_W-1:0]        cal_cnt;
    int                          tick = 0, n_fail = 0, checks_done = 0;
    int                          cnt [17], base [17], dlt [17];
    int                          per_tab [5] = '{4, 14, 6, 22, 10};

    initial
    begin
        forever #10 clock_i = ~clock_i;
    end

    // oscillator pins change at falling edges only
    always @(negedge clock_i) tick <= tick + 1;

    // pulse counters: 0 root, 1 low power, 2 radio active, 3 radio sleep, 4 watchdog
    always @(posedge clock_i)
    begin
        cnt[0] <= cnt[0] + int'(root_en);
        cnt[1] <= cnt[1] + int'(lp_en);
        cnt[2] <= cnt[2] + int'(ra_en);
        cnt[3] <= cnt[3] + int'(rs_en);
        cnt[4] <= cnt[4] + int'(wdt_en);
        for (int k = 0; k < DIV_N; k++) cnt[5+k] <= cnt[5+k] + int'(per_en[k]);
    end

    scc_top scc_top_i (
        .clock_i                    (clock_i),
        .nrst_i                     (nrst_i),
        .main_rc_oscillator_i       ((tick % 4) < 2),
        .low_speed_rc_oscillator_i  ((tick % 14) < 7),
        .fast_crystal_oscillator_i  ((tick % 6) < 3),
        .watch_crystal_oscillator_i ((tick % 22) < 11),
        .ext_clk_pin_i              ((tick % 10) < 5),
        .src_sel_i                  (src_sel_i),
        .src_sel_we_i               (src_sel_we_i),
        .deep_sleep_i               (deep_sleep_i),
        .wdt_src_watch_i            (wdt_src_watch_i),
        .trim_latch_store_i         (trim_latch_store_i),
        .flash_trim_i               (flash_trim_i),
        .flash_trim_we_i            (flash_trim_we_i),
        .freq_mhz_i                 (freq_mhz_i),
        .freq_we_i                  (freq_we_i),
        .div_int_i                  (div_int_i),
        .div_frac_i                 (div_frac_i),
        .cal_start_i                (cal_start_i),
        .cal_len_i                  (cal_len_i),
        .high_freq_root_clock_en_o  (root_en),
        .lp_periph_clk_en_o         (lp_en),
        .radio_active_clk_en_o      (ra_en),
        .radio_sleep_clk_en_o       (rs_en),
        .wdt_clk_en_o               (wdt_en),
        .periph_clk_en_o            (per_en),
        .active_src_o               (act_src),
        .switch_busy_o              (busy),
        .main_rc_trim_o             (trim_o),
        .main_rc_freq_o             (freq_o),
        .cal_count_o                (cal_cnt),
        .cal_done_o                 (cal_done)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic near(input int d, input int e, input int t);
        return (d >= e - t) && (d <= e + t);
    endfunction

    task automatic end_sim();
        if (n_fail == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic measure(input int w);
        base = cnt;
        repeat (w) @(negedge clock_i);
        for (int k = 0; k < 17; k++) dlt[k] = cnt[k] - base[k];
    endtask

    task automatic pulse_src(input logic [SRC_W-1:0] code);
        src_sel_i = code;
        src_sel_we_i = 1'b1;
        @(negedge clock_i);
        src_sel_we_i = 1'b0;
        @(negedge clock_i);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 400)
        begin
            @(negedge clock_i);
            n++;
        end
        check(n < 400, 1'b1);
    endtask

    task automatic t_reset_state();
        check(act_src, SRC_MAIN_RC);
        check(freq_o, FREQ_DFLT);
        check(trim_o, 8'ha5);
        check(busy, 1'b0);
    endtask

    task automatic t_trim();
        trim_latch_store_i = 8'h11;
        flash_trim_i = 8'h70;
        flash_trim_we_i = 1'b1;
        @(negedge clock_i);
        flash_trim_we_i = 1'b0;
        @(negedge clock_i);
        check(trim_o, 8'h15);
    endtask

    task automatic t_freq();
        logic [5:0] codes [6] = '{6'h30, 6'h31, 6'h02, 6'h03, 6'h00, 6'h18};
        logic [5:0] exps [6] = '{6'h30, 6'h30, 6'h30, 6'h03, 6'h03, 6'h18};
        for (int i = 0; i < 6; i++)
        begin
            freq_mhz_i = codes[i];
            freq_we_i = 1'b1;
            @(negedge clock_i);
            freq_we_i = 1'b0;
            @(negedge clock_i);
            check(freq_o, exps[i]);
        end
    endtask

    task automatic t_switch_all();
        logic [SRC_W-1:0] codes [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h0};
        pulse_src(3'h5);
        check(busy, 1'b0);
        pulse_src(SRC_MAIN_RC);
        check(busy, 1'b0);
        for (int i = 0; i < 5; i++)
        begin
            pulse_src(codes[i]);
            check(busy, 1'b1);
            wait_idle();
            check(act_src, codes[i]);
            repeat (30) @(negedge clock_i);
            measure(440);
            check(near(dlt[0], 440 / per_tab[codes[i]], 2), 1'b1);
        end
    endtask

    task automatic t_busy_refuse();
        pulse_src(SRC_FAST_XO);
        pulse_src(SRC_LOW_RC);
        wait_idle();
        check(act_src, SRC_FAST_XO);
        pulse_src(SRC_MAIN_RC);
        wait_idle();
        check(act_src, SRC_MAIN_RC);
    endtask

    task automatic t_sleep();
        measure(440);
        check(near(dlt[2], 440 / 6, 2), 1'b1);
        deep_sleep_i = 1'b1;
        repeat (10) @(negedge clock_i);
        measure(440);
        check(dlt[0], 0);
        check(dlt[2], 0);
        check(near(dlt[1], 440 / 14, 2), 1'b1);
        check(near(dlt[3], 440 / 22, 2), 1'b1);
        deep_sleep_i = 1'b0;
    endtask

    task automatic t_dividers();
        for (int i = 0; i < DIV_N; i++) div_int_i[DIV_W*i +: DIV_W] = 16'(i);
        repeat (60) @(negedge clock_i);
        measure(800);
        for (int i = 0; i < DIV_N; i++)
            check(near(dlt[5+i], dlt[0] / (i + 1), 1), 1'b1);
        div_int_i[DIV_W*10 +: DIV_W] = DIV_ONE;
        div_frac_i[FRAC_W-1:0] = 5'h10;
        repeat (60) @(negedge clock_i);
        measure(800);
        check(near(dlt[15], dlt[0] * 2 / 5, 2), 1'b1);
    endtask

    task automatic t_wdt();
        measure(440);
        check(near(dlt[4], 440 / 14, 2), 1'b1);
        wdt_src_watch_i = 1'b1;
        repeat (10) @(negedge clock_i);
        measure(440);
        check(near(dlt[4], 440 / 22, 2), 1'b1);
    endtask

    task automatic t_cal();
        int n;
        n = 0;
        while (lp_en !== 1'b1 && n < 40)
        begin
            @(negedge clock_i);
            n++;
        end
        n = 0;
        cal_start_i = 1'b1;
        @(negedge clock_i);
        cal_start_i = 1'b0;
        check(cal_done, 1'b0);
        while (cal_done !== 1'b1 && n < 300)
        begin
            @(negedge clock_i);
            n++;
        end
        check(cal_done, 1'b1);
        check(near(int'(cal_cnt), 3 * 14 / 4, 1), 1'b1);
    endtask

    initial
    begin
        repeat (20) @(negedge clock_i);
        nrst_i = 1'b1;
        repeat (3) @(negedge clock_i);
        t_reset_state();
        t_trim();
        t_freq();
        t_switch_all();
        t_busy_refuse();
        t_sleep();
        t_dividers();
        t_wdt();
        t_cal();
        t_cal();
        end_sim();
    end

    initial
    begin
        repeat (30000) @(posedge clock_i);
        n_fail++;
        end_sim();
    end
endmodule
